/* design/udma_din_burst.sv */
`timescale 1ns/1ns
// Contract
// R1: drive each word, wait tDVS after data change before its strobe edge.
// R2: strobe edges at least tCYC apart, same polarity at least 2*tCYC.
// R3: hold data at least tDVH after each latching strobe edge.
// R4: repeat word, strobe, hold until finished or paused.
// R5: host pauses only after one word, by negating HDMARDY.
// R6: stop strobe edges within tRFS of HDMARDY negation.
// R7: host accepts up to two extra words, three in modes 3 and 4.
// R8: host resumes a paused burst by reasserting HDMARDY.
// R9: host asserts STOP at least tRP after HDMARDY negation, holds it.
// R10: device pauses after one word by withholding strobe edges, resumes with edge.
// R11: host must negate HDMARDY and wait tRP before STOP when device idles.
// R12: host terminates after one word, keeps HDMARDY negated until end.
// R13: drop DMARQ within tLI of STOP, no new request until burst ends.
// R14: if strobe negated at STOP, assert it within tLI, carries no data.
// R15: release data bus within tAZ of DMARQ negation; host drives after tZAH.
// R16: host presents its CRC on the data bus during termination.
// R17: host negates DMACK tMLI after end states and tDVS after CRC.
// R18: capture host CRC from data bus on DMACK negation.
// R19: compare CRCs, report first miscompare of a command at command end.
// R20: release strobe within tIORDYZ after DMACK negation.
// R21: host waits tACK after DMACK negation before STOP or HDMARDY changes.
// R22: host waits tACK after DMACK negation before read strobe, selects, address.
// R23: once DMARQ raised, keep it until the first strobe negation.
// R24: strobe, ready and stop meanings hold only while DMARQ and DMACK asserted.
// R25: accumulate 16-bit CRC over every word sent with standard polynomial, seed.
// R26: per-mode intervals as cycle counters from own clock, chosen by mode.
module udma_din_burst
  import udma_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // user side
  input  wire logic [2:0]        mode,
  input  wire logic              burst_req,
  input  wire logic              word_valid,
  input  wire logic [15:0]       word_data,
  output logic                   word_take,
  input  wire logic              cmd_end,
  output logic                   crc_err,
  output logic [15:0]            crc_bad,
  output logic                   busy,
  // link pins
  input  wire udma_pkg::link_in_t  pin_in,
  output udma_pkg::link_out_t      pin_out
);
  import udma_pkg::*;

  link_in_t        s1_q, s2_q;
  logic            dmack_n_prev_q;
  state_t          state_q;
  link_out_t       out_q;
  logic [2:0]      mode_q;
  logic [CW-1:0]   data_age_q, edge_age_q;
  logic            first_done_q, take_q;
  logic [15:0]     crc_q, crc_rx_q;
  logic            err_q, err_out_q;
  logic [15:0]     bad_q, bad_out_q;
  logic            ack_on, rdy_s, stop_s, ack_fall, load_c, tgl_c, miss_c, busy_q;
  logic [CW-1:0]   cyc_c, dvs_c, dvh_c;
  logic [2:0]      midx;

  // link inputs are asynchronous: two flops, nothing reads the first
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '{dmack_n: 1'b1, hdmardy_n: 1'b1, stop: 1'b0, d: DATA_RST};
      s2_q <= '{dmack_n: 1'b1, hdmardy_n: 1'b1, stop: 1'b0, d: DATA_RST};
      dmack_n_prev_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      dmack_n_prev_q <= s2_q.dmack_n;
    end
  end

  // shared pins mean ready and stop only inside an acknowledged request
  assign ack_on   = out_q.dmarq && !s2_q.dmack_n; // R24
  assign rdy_s    = ack_on && !s2_q.hdmardy_n; // R24
  assign stop_s   = ack_on && s2_q.stop; // R24
  assign ack_fall = s2_q.dmack_n && !dmack_n_prev_q;

  // mode-selected interval counts
  assign midx  = (mode_q < 3'(NMODES)) ? mode_q : 3'(NMODES - 1);
  assign cyc_c = min_cyc(T_CYC_NS[midx]); // R26
  assign dvs_c = min_cyc(T_DVS_NS[midx]); // R26
  assign dvh_c = min_cyc(T_DVH_NS[midx]); // R26

  // one definition of load and edge, shared by the counters and the sequencer
  assign load_c = (state_q == ST_REQ && out_q.dstrobe_oe && rdy_s && !s2_q.stop &&
                   word_valid) ||
                  (state_q == ST_HOLD && !(stop_s && first_done_q) && rdy_s && word_valid &&
                   edge_age_q >= dvh_c);
  assign tgl_c  = state_q == ST_SETUP && !(stop_s && first_done_q) && rdy_s &&
                  data_age_q >= dvs_c && edge_age_q >= cyc_c;
  assign miss_c = state_q == ST_DONE && ack_fall && s2_q.d != crc_q;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ w[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // age counters saturate so long pauses never wrap
  always_ff @(posedge clk) begin
    if (srst) begin
      data_age_q <= '0;
      edge_age_q <= '0;
    end else begin
      // counted from the load edge itself, so setup runs from when the pins change
      data_age_q <= (load_c) ? '0 : ((&data_age_q) ? data_age_q : data_age_q + 1'b1);
      if (tgl_c) begin // R2
        edge_age_q <= '0;
      end else if (!(&edge_age_q)) begin
        edge_age_q <= edge_age_q + 1'b1;
      end
    end
  end

  // burst sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q      <= ST_IDLE;
      out_q        <= '{dmarq: 1'b0, dstrobe: 1'b0, dstrobe_oe: 1'b0, d_oe: 1'b0, d: DATA_RST};
      mode_q       <= MODE_RST;
      first_done_q <= 1'b0;
      take_q       <= 1'b0;
      crc_q        <= CRC_SEED;
      crc_rx_q     <= DATA_RST;
    end else begin
      take_q <= 1'b0;
      unique case (state_q)
        ST_IDLE: begin
          if (burst_req) begin
            out_q.dmarq  <= 1'b1;
            mode_q       <= mode;
            crc_q        <= CRC_SEED;
            first_done_q <= 1'b0;
            state_q      <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (!s2_q.dmack_n) begin
            out_q.dstrobe_oe <= 1'b1;
            out_q.dstrobe    <= 1'b1;
          end
          if (load_c) begin
            out_q.d    <= word_data; // R1
            out_q.d_oe <= 1'b1;
            take_q     <= 1'b1;
            state_q    <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // no ready means pause: no edge issues, latency stays under tRFS
          if (stop_s && first_done_q) begin
            state_q <= ST_TERM;
          end else if (tgl_c) begin // R1 R2 R6
            out_q.dstrobe <= !out_q.dstrobe;
            // crc takes only strobed words; a word cut off by stop never counts
            crc_q         <= crc_step(crc_q, out_q.d); // R25
            first_done_q  <= 1'b1; // R23
            state_q       <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (stop_s && first_done_q) begin
            state_q <= ST_TERM;
          end else if (load_c) begin // R3 R4 R10
            out_q.d <= word_data;
            take_q  <= 1'b1;
            state_q <= ST_SETUP;
          end
        end
        ST_TERM: begin
          out_q.dmarq   <= 1'b0; // R13
          out_q.d_oe    <= 1'b0; // R15
          out_q.dstrobe <= 1'b1; // R14
          state_q       <= ST_DONE;
        end
        ST_DONE: begin
          // stays out of idle until dmack drops, so no early re-request
          if (ack_fall) begin
            crc_rx_q         <= s2_q.d; // R18
            out_q.dstrobe_oe <= 1'b0; // R20
            state_q          <= ST_IDLE; // R13
          end
        end
      endcase
    end
  end

  // first miscompare of a command is kept until the command ends
  always_ff @(posedge clk) begin
    if (srst) begin
      err_q     <= 1'b0;
      bad_q     <= DATA_RST;
      err_out_q <= 1'b0;
      bad_out_q <= DATA_RST;
    end else begin
      // a miscompare in the cycle of cmd_end still counts for the ending command
      if (cmd_end) begin
        err_out_q <= err_q || miss_c; // R19
        bad_out_q <= (err_q || !miss_c) ? bad_q : s2_q.d;
        err_q     <= 1'b0;
      end else if (miss_c && !err_q) begin // R19
        err_q <= 1'b1;
        bad_q <= s2_q.d;
      end
    end
  end

  assign pin_out   = out_q;
  assign word_take = take_q;
  assign crc_err   = err_out_q;
  assign crc_bad   = bad_out_q;
  assign busy      = busy_q;

  // registered, so busy trails the sequencer by one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != ST_IDLE) || out_q.dstrobe_oe;
    end
  end

  // checks
  sequence s_ready_gone;
    !rdy_s [*2];
  endsequence
  property p_setup;
    @(posedge clk) disable iff (srst)
      ($changed(out_q.dstrobe) && $past(state_q) == ST_SETUP) |-> $past(data_age_q) >= dvs_c;
  endproperty
  a_setup: assert property (p_setup) else $error("strobe edge before data setup"); // R1
  property p_cycle;
    @(posedge clk) disable iff (srst)
      (state_q == ST_HOLD && $past(state_q) == ST_SETUP) |-> $past(edge_age_q) >= cyc_c;
  endproperty
  a_cycle: assert property (p_cycle) else $error("strobe edges too close"); // R2
  property p_hold;
    @(posedge clk) disable iff (srst)
      (state_q == ST_SETUP && $past(state_q) == ST_HOLD) |-> $past(edge_age_q) >= dvh_c;
  endproperty
  a_hold: assert property (p_hold) else $error("data changed inside hold"); // R3
  property p_pause;
    @(posedge clk) disable iff (srst)
      (s_ready_gone ##0 (state_q == ST_SETUP || state_q == ST_HOLD)) |=> $stable(out_q.dstrobe);
  endproperty
  a_pause: assert property (p_pause) else $error("strobe edge while paused"); // R6
  property p_stop;
    @(posedge clk) disable iff (srst)
      (stop_s && first_done_q && (state_q == ST_SETUP || state_q == ST_HOLD))
        |-> ##2 !out_q.dmarq && out_q.dstrobe;
  endproperty
  a_stop: assert property (p_stop) else $error("no dmarq drop or strobe after stop"); // R13 R14
  property p_release;
    @(posedge clk) disable iff (srst)
      $fell(out_q.dmarq) |-> !out_q.d_oe;
  endproperty
  a_release: assert property (p_release) else $error("bus still driven"); // R15
  property p_capture;
    @(posedge clk) disable iff (srst)
      (state_q == ST_DONE && ack_fall) |=> crc_rx_q == $past(s2_q.d) && !out_q.dstrobe_oe;
  endproperty
  a_capture: assert property (p_capture) else $error("crc capture or strobe release"); // R18 R20
  property p_first;
    @(posedge clk) disable iff (srst)
      (state_q == ST_SETUP && !first_done_q) |=> out_q.dmarq;
  endproperty
  a_first: assert property (p_first) else $error("dmarq dropped before first word"); // R23
endmodule

/* design/udma_pkg.sv */
package udma_pkg;
  // clock and mode table
  localparam int CLK_NS  = 10;
  localparam int NMODES  = 5;
  localparam int CW      = 8;
  localparam int DW      = 16;
  // per-mode times in ns, modes 0..4 (plain defaults)
  localparam int T_CYC_NS [NMODES] = '{120, 80, 60, 45, 30};
  localparam int T_DVS_NS [NMODES] = '{70, 50, 35, 25, 10};
  localparam int T_DVH_NS [NMODES] = '{10, 10, 10, 10, 10};
  // crc polynomial x^16+x^12+x^5+1 and seed
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'h4aba;
  // reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [2:0]  MODE_RST = 3'h0;

  // least time rounds up, never below one cycle
  function automatic logic [CW-1:0] min_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) c = 1;
    return CW'(c);
  endfunction

  typedef struct packed {
    logic          dmarq;
    logic          dstrobe;
    logic          dstrobe_oe;
    logic          d_oe;
    logic [DW-1:0] d;
  } link_out_t;

  typedef struct packed {
    logic          dmack_n;
    logic          hdmardy_n;
    logic          stop;
    logic [DW-1:0] d;
  } link_in_t;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_REQ   = 6'b000010,
    ST_SETUP = 6'b000100,
    ST_HOLD  = 6'b001000,
    ST_TERM  = 6'b010000,
    ST_DONE  = 6'b100000
  } state_t;
endpackage

/* verif/udma_host_model.sv */
`timescale 1ns/1ns
module udma_host_model (
  // clock and host commands
  input  wire logic                clk,
  input  wire logic                rdy,
  input  wire logic                term,
  input  wire logic [15:0]         crc_val,
  // link pins
  input  wire udma_pkg::link_out_t pin_out,
  output udma_pkg::link_in_t       pin_in,
  // received words
  output logic                     rx_pulse,
  output logic [15:0]              rx_word
);
  import udma_pkg::*;
  logic        dk_n = 1'b1, hr_n = 1'b1, stp = 1'b1, drv = 1'b0;
  logic        pat = 1'b0, oe_q = 1'b0, st_q = 1'b0;
  logic [15:0] hd = 16'h0000;
  int          n = 0;
  // a released bus toggles, so a stale value never passes for data
  assign pin_in = {dk_n, hr_n, stp, drv ? hd : pin_out.d_oe ? pin_out.d : {16{pat}}};
  always @(posedge clk) begin
    pat <= ~pat;
    oe_q <= pin_out.dstrobe_oe;
    st_q <= pin_out.dstrobe;
    rx_pulse <= !dk_n && !stp && oe_q && pin_out.dstrobe != st_q;
    rx_word <= pin_in.d;
    n <= dk_n ? 0 : n + int'(rx_pulse);
  end
  initial forever begin
    @(negedge clk);
    if (pin_out.dmarq) begin
      dk_n = 1'b0;
      repeat (2) @(negedge clk);
      {stp, hr_n} = 2'b00;
      while (!(term && n > 0)) begin
        @(negedge clk);
        if (n > 0) hr_n = !rdy;
      end
      hr_n = 1'b1;
      repeat (4) @(negedge clk);
      stp = 1'b1;
      while (pin_out.dmarq) @(negedge clk);
      repeat (2) @(negedge clk);
      {drv, hd} = {1'b1, crc_val};
      repeat (3) @(negedge clk);
      dk_n = 1'b1;
      repeat (3) @(negedge clk);
      drv = 1'b0;
    end
  end
endmodule

/* verif/udma_din_burst_tb.sv */
`timescale 1ns/1ns
module udma_din_burst_tb;
  import udma_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, burst_req = 1'b0, word_valid = 1'b0, cmd_end = 1'b0;
  logic        rdy = 1'b1, term = 1'b0, chg = 1'b0, ps = 1'b0;
  logic        word_take, crc_err, busy, rx_pulse;
  logic [2:0]  mode = 3'h0;
  logic [15:0] word_data = 16'h0000, tcrc = 16'h0000, flip = 16'h0000, pd = 16'h0000;
  logic [15:0] crc_bad, rx_word, first;
  link_in_t    pin_in;
  link_out_t   pin_out;
  int          errors = 0, compares = 0, md = 0, words = 0;
  int          dchg = 0, edg = 99, late = 0, sc = 0, rc = 0;
  logic [15:0] sent [$];
  udma_din_burst dut (.clk(clk), .srst(srst), .mode(mode), .burst_req(burst_req),
    .word_valid(word_valid), .word_data(word_data), .word_take(word_take), .cmd_end(cmd_end),
    .crc_err(crc_err), .crc_bad(crc_bad), .busy(busy), .pin_in(pin_in), .pin_out(pin_out));
  udma_host_model host (.clk(clk), .rdy(rdy), .term(term), .crc_val(tcrc ^ flip),
    .pin_out(pin_out), .pin_in(pin_in), .rx_pulse(rx_pulse), .rx_word(rx_word));
  initial forever #5 clk = ~clk;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] w);
    for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    if (word_take) begin
      sent.push_back(word_data);
      chg = 1'b1;
    end
    if (rx_pulse) begin
      words++;
      tcrc = crc_step(tcrc, rx_word);
      chk(rx_word, sent.size() > 0 ? sent.pop_front() : 16'hdead);
    end
    if (!pin_in.dmack_n) begin
      rc = 0;
      sc = pin_in.stop ? sc + 1 : 0;
      // late counts strobe edges inside one unbroken negation of ready
      late = pin_in.hdmardy_n ? late : 0;
      if (sc > 7) chk(16'({pin_out.dmarq, pin_out.dstrobe, pin_out.d_oe}), 16'h0002);
      if (pin_out.dstrobe != ps && pin_out.d_oe && pin_out.dmarq) begin
        chk(16'(dchg >= (T_DVS_NS[md] + 9) / 10), 16'h0001);
        chk(16'(edg >= (T_CYC_NS[md] + 9) / 10), 16'h0001);
        late = late + int'(pin_in.hdmardy_n);
        chk(16'(late <= (md > 2 ? 3 : 2)), 16'h0001);
        edg = 0;
      end
      if (pin_out.d != pd && pin_out.d_oe) begin
        chk(16'(edg >= (T_DVH_NS[md] + 9) / 10), 16'h0001);
        dchg = 0;
      end
    end else begin
      {edg, late, sc} = {32'd99, 32'd0, 32'd0};
      rc++;
      if (rc > 6) chk(16'(pin_out.dstrobe_oe), 16'h0000);
    end
    edg++;
    dchg++;
    ps = pin_out.dstrobe;
    pd = pin_out.d;
  end
  // new data only after the previous word was taken, so it cannot tear
  always @(negedge clk) if (chg) begin
    word_data = 16'($urandom);
    chg = 1'b0;
  end
  task automatic burst(input int nw, input logic [15:0] f);
    int k;
    {words, tcrc, flip} = {32'd0, CRC_SEED, f};
    sent.delete();
    @(negedge clk);
    burst_req = 1'b1;
    for (k = 0; k < 5000 && words < nw; k++) begin
      @(negedge clk);
      burst_req = 1'b0;
      rdy = ($urandom % 5) != 0;
      word_valid = ($urandom % 6) != 0;
    end
    chk(16'(words >= nw), 16'h0001);
    {rdy, term} = 2'b11;
    for (k = 0; k < 300 && !(busy === 1'b0 && pin_in.dmack_n); k++) @(negedge clk);
    chk(16'(busy), 16'h0000);
    term = 1'b0;
  endtask
  task automatic cmd(input logic err, input logic [15:0] bad);
    @(negedge clk);
    cmd_end = 1'b1;
    @(negedge clk);
    cmd_end = 1'b0;
    @(negedge clk);
    chk(16'(crc_err), 16'(err));
    if (err) chk(crc_bad, bad);
  endtask
  initial begin
    #1000000;
    errors++;
    summarize();
  end
  initial begin
    void'($urandom(97));
    repeat (3) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    // mode 7 runs as mode 4
    for (int m = 0; m < 6; m++) begin
      md = (m > 4) ? 4 : m;
      mode = (m > 4) ? 3'h7 : 3'(m);
      burst(30, 16'h0000);
      cmd(1'b0, 16'h0000);
    end
    burst(25, 16'h0001);
    first = tcrc ^ flip;
    burst(25, 16'h0100);
    cmd(1'b1, first);
    burst(10, 16'h0000);
    cmd(1'b0, 16'h0000);
    summarize();
  end
endmodule
